/* hdl/e1cib_defines.vh */
// Constants of the E1 channel idle, substitution and gating block.
// Assumes registers are word aligned on APB: byte address = 4 * index.
`ifndef E1CIB_DEFINES_VH
`define E1CIB_DEFINES_VH

`define E1CIB_IDX_TX_GATE_1     6'h22
`define E1CIB_IDX_TX_GATE_2     6'h23
`define E1CIB_IDX_TX_GATE_3     6'h24
`define E1CIB_IDX_TX_GATE_4     6'h25
`define E1CIB_IDX_IDLE_SEL_1    6'h26
`define E1CIB_IDX_IDLE_SEL_2    6'h27
`define E1CIB_IDX_IDLE_SEL_3    6'h28
`define E1CIB_IDX_IDLE_SEL_4    6'h29
`define E1CIB_IDX_IDLE_PATTERN  6'h2A
`define E1CIB_IDX_RX_GATE_1     6'h2B
`define E1CIB_IDX_RX_GATE_2     6'h2C
`define E1CIB_IDX_RX_GATE_3     6'h2D
`define E1CIB_IDX_RX_GATE_4     6'h2E
`define E1CIB_IDX_CONTROL       6'h1C
`define E1CIB_IDX_STATUS        6'h1D

`define E1CIB_CTRL_SUBST_BIT    5
`define E1CIB_CTRL_SIGMODE_BIT  6

`define E1CIB_GATE_RESET        32'h00000000
`define E1CIB_IDLE_SEL_RESET    32'h00000000
`define E1CIB_PATTERN_RESET     8'h00
`define E1CIB_CTRL_RESET        8'h00

`define E1CIB_BIT_DIV           5
`define E1CIB_FIFO_DEPTH        8
`define E1CIB_FIFO_ADDR_W       3
`define E1CIB_FIFO_WIDTH        2

`endif

/* hdl/e1cib_fifo.v */
// Small FIFO with registered read data and valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/100ps
module e1cib_fifo #(
  parameter WIDTH  = 2,
  parameter DEPTH  = 8,
  parameter ADDR_W = 3
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  localparam [31:0]       DEPTH_W  = DEPTH;
  localparam [ADDR_W:0]   FULL_CNT = DEPTH_W[ADDR_W:0];
  localparam [ADDR_W-1:0] PTR_ONE  = {{(ADDR_W-1){1'b0}}, 1'b1};
  localparam [ADDR_W:0]   CNT_ONE  = {{ADDR_W{1'b0}}, 1'b1};

  reg [WIDTH-1:0]  mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_reg;
  reg [ADDR_W-1:0] rd_ptr_reg;
  reg [ADDR_W:0]   count_reg;
  reg [WIDTH-1:0]  out_data_reg;
  reg              out_valid_reg;
  wire             push;
  wire             pop;

  assign in_ready  = (count_reg != FULL_CNT);
  assign push      = in_valid & in_ready;
  // Output stage refills as soon as it is empty or being taken
  assign pop       = (count_reg != {(ADDR_W+1){1'b0}}) & (~out_valid_reg | out_ready);
  assign out_data  = out_data_reg;
  assign out_valid = out_valid_reg;

  always @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg    <= {ADDR_W{1'b0}};
      rd_ptr_reg    <= {ADDR_W{1'b0}};
      count_reg     <= {(ADDR_W+1){1'b0}};
      out_data_reg  <= {WIDTH{1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_reg    <= rd_ptr_reg + PTR_ONE;
        out_data_reg  <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + CNT_ONE;
      end else if (pop & ~push) begin
        count_reg <= count_reg - CNT_ONE;
      end
    end
  end
endmodule

/* hdl/e1cib_slot_timer.v */
// Bit and channel counter of one E1 frame direction.
// Assumes advance and frame_start are single-cycle pulses on pclk.
`timescale 1ns/100ps
module e1cib_slot_timer (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       advance,
  input  wire       frame_start,
  output wire [2:0] bit_pos,
  output wire [4:0] channel
);
  reg [7:0] slot_reg;

  assign bit_pos = slot_reg[2:0];
  assign channel = slot_reg[7:3];

  // Eight bits per channel, 32 channels: the 8-bit count wraps once per frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg <= 8'h00;
    end else if (frame_start) begin
      slot_reg <= 8'h00;
    end else if (advance) begin
      slot_reg <= slot_reg + 8'h01;
    end
  end
endmodule

/* hdl/e1cib_top.v */
// E1 per-channel idle insertion, data substitution and channel gating.
// Assumes APB master on pclk; serial and frame-sync pins are asynchronous.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "e1cib_defines.vh"
module e1cib_top #(
  parameter BIT_DIV    = `E1CIB_BIT_DIV,
  parameter FIFO_DEPTH = `E1CIB_FIFO_DEPTH,
  parameter FIFO_AW    = `E1CIB_FIFO_ADDR_W
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        transmit_serial_in,
  input  wire        receive_serial_out,
  input  wire        rx_frame_sync,
  input  wire        tx_frame_sync,
  output wire        rx_channel_gate,
  output wire        tx_channel_gate,
  output wire        tx_line_data,
  output wire        tx_line_sig_internal,
  output wire        tx_line_valid,
  input  wire        tx_line_ready
);
  localparam [31:0] DIV_LAST_W = BIT_DIV - 1;
  localparam [7:0]  DIV_LAST   = DIV_LAST_W[7:0];
  localparam [2:0]  PH_IDLE    = 3'h1;
  localparam [2:0]  PH_SETUP   = 3'h2;
  localparam [2:0]  PH_ACCESS  = 3'h4;

  reg  [31:0] tx_gate_bits_reg;
  reg  [31:0] rx_gate_bits_reg;
  reg  [31:0] idle_sel_reg;
  reg  [7:0]  idle_pattern_reg;
  reg  [7:0]  control_reg;
  reg  [31:0] prdata_reg;
  reg  [31:0] prdata_next;
  reg         pslverr_reg;
  reg         map_hit;
  reg  [7:0]  div_reg;
  reg         bit_tick_reg;
  reg         tx_pend_reg;
  reg  [2:0]  tx_ser_sync_reg;
  reg  [2:0]  rx_ser_sync_reg;
  reg  [2:0]  rx_fs_sync_reg;
  reg  [2:0]  tx_fs_sync_reg;
  reg         rx_gate_reg;
  reg         tx_gate_reg;
  reg         tx_bit_next;
  reg  [2:0]  phase_reg;
  reg  [2:0]  phase_next;
  wire [5:0]  index;
  wire        wr_en;
  wire        rd_setup;
  wire        subst_on;
  wire        sig_mode;
  wire [2:0]  rx_bit_pos;
  wire [4:0]  rx_channel;
  wire [2:0]  tx_bit_pos;
  wire [4:0]  tx_channel;
  wire        rx_fs_pulse;
  wire        tx_fs_pulse;
  wire        fifo_in_ready;
  wire        tx_push;
  wire [4:0]  sig_index;
  wire        sig_internal;
  wire [1:0]  fifo_out;

  assign index    = paddr[7:2];
  assign wr_en    = psel & penable & pwrite & (paddr[1:0] == 2'b00) & (phase_reg == PH_SETUP);
  assign rd_setup = psel & ~penable;
  assign pready   = 1'b1;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;
  assign subst_on = control_reg[`E1CIB_CTRL_SUBST_BIT];
  assign sig_mode = control_reg[`E1CIB_CTRL_SIGMODE_BIT];

  // One-hot bus phase: a write lands only in an access cycle right after a setup
  // cycle, so a stray penable without a setup cannot corrupt a register
  always @* begin
    phase_next = PH_IDLE;
    case (phase_reg)
      PH_IDLE: begin
        if (psel & ~penable) begin
          phase_next = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (psel & penable) begin
          phase_next = PH_ACCESS;
        end else if (psel) begin
          phase_next = PH_SETUP;
        end
      end
      PH_ACCESS: begin
        if (psel & ~penable) begin
          phase_next = PH_SETUP;
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Byte lanes of the three 32-channel banks; bank byte k covers channels 8k+1..8k+8
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_bank
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_gate_bits_reg[8*k+7:8*k] <= 8'h00;
          rx_gate_bits_reg[8*k+7:8*k] <= 8'h00;
          idle_sel_reg[8*k+7:8*k]     <= 8'h00;
        end else if (wr_en) begin
          if (index == `E1CIB_IDX_TX_GATE_1 + k) begin
            tx_gate_bits_reg[8*k+7:8*k] <= pwdata[7:0];
          end
          if (index == `E1CIB_IDX_RX_GATE_1 + k) begin
            rx_gate_bits_reg[8*k+7:8*k] <= pwdata[7:0];
          end
          if (index == `E1CIB_IDX_IDLE_SEL_1 + k) begin
            idle_sel_reg[8*k+7:8*k] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_pattern_reg <= `E1CIB_PATTERN_RESET;
      control_reg      <= `E1CIB_CTRL_RESET;
    end else if (wr_en) begin
      if (index == `E1CIB_IDX_IDLE_PATTERN) begin
        idle_pattern_reg <= pwdata[7:0];
      end
      if (index == `E1CIB_IDX_CONTROL) begin
        control_reg <= pwdata[7:0] & 8'h60;
      end
    end
  end

  // Read data is latched in the setup cycle so the access cycle needs no wait
  always @* begin
    prdata_next = 32'h00000000;
    map_hit     = 1'b1;
    case (index)
      `E1CIB_IDX_TX_GATE_1:   prdata_next[7:0] = tx_gate_bits_reg[7:0];
      `E1CIB_IDX_TX_GATE_2:   prdata_next[7:0] = tx_gate_bits_reg[15:8];
      `E1CIB_IDX_TX_GATE_3:   prdata_next[7:0] = tx_gate_bits_reg[23:16];
      `E1CIB_IDX_TX_GATE_4:   prdata_next[7:0] = tx_gate_bits_reg[31:24];
      `E1CIB_IDX_IDLE_SEL_1:  prdata_next[7:0] = idle_sel_reg[7:0];
      `E1CIB_IDX_IDLE_SEL_2:  prdata_next[7:0] = idle_sel_reg[15:8];
      `E1CIB_IDX_IDLE_SEL_3:  prdata_next[7:0] = idle_sel_reg[23:16];
      `E1CIB_IDX_IDLE_SEL_4:  prdata_next[7:0] = idle_sel_reg[31:24];
      `E1CIB_IDX_IDLE_PATTERN: prdata_next[7:0] = idle_pattern_reg;
      `E1CIB_IDX_RX_GATE_1:   prdata_next[7:0] = rx_gate_bits_reg[7:0];
      `E1CIB_IDX_RX_GATE_2:   prdata_next[7:0] = rx_gate_bits_reg[15:8];
      `E1CIB_IDX_RX_GATE_3:   prdata_next[7:0] = rx_gate_bits_reg[23:16];
      `E1CIB_IDX_RX_GATE_4:   prdata_next[7:0] = rx_gate_bits_reg[31:24];
      `E1CIB_IDX_CONTROL:     prdata_next[7:0] = control_reg;
      `E1CIB_IDX_STATUS:      prdata_next[15:0] = {rx_channel, rx_bit_pos,
                                                   tx_channel, tx_bit_pos};
      default: begin
        map_hit = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'b00) begin
      map_hit     = 1'b0;
      prdata_next = 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
      pslverr_reg <= ~map_hit;
    end else if (~psel) begin
      pslverr_reg <= 1'b0;
    end
  end

  // Pins pass two flip-flops; edge detection looks only at stages two and three
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ser_sync_reg <= 3'b000;
      rx_ser_sync_reg <= 3'b000;
      rx_fs_sync_reg  <= 3'b000;
      tx_fs_sync_reg  <= 3'b000;
    end else begin
      tx_ser_sync_reg <= {tx_ser_sync_reg[1:0], transmit_serial_in};
      rx_ser_sync_reg <= {rx_ser_sync_reg[1:0], receive_serial_out};
      rx_fs_sync_reg  <= {rx_fs_sync_reg[1:0], rx_frame_sync};
      tx_fs_sync_reg  <= {tx_fs_sync_reg[1:0], tx_frame_sync};
    end
  end

  assign rx_fs_pulse = rx_fs_sync_reg[1] & ~rx_fs_sync_reg[2];
  assign tx_fs_pulse = tx_fs_sync_reg[1] & ~tx_fs_sync_reg[2];

  // Internal bit clock; the transmit bit waits while the FIFO is full
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg      <= 8'h00;
      bit_tick_reg <= 1'b0;
      tx_pend_reg  <= 1'b0;
    end else begin
      bit_tick_reg <= (div_reg == DIV_LAST);
      div_reg      <= (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
      if (bit_tick_reg) begin
        tx_pend_reg <= 1'b1;
      end else if (tx_push) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  assign tx_push = tx_pend_reg & fifo_in_ready;

  e1cib_slot_timer u_rx_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .advance     (bit_tick_reg),
    .frame_start (rx_fs_pulse),
    .bit_pos     (rx_bit_pos),
    .channel     (rx_channel)
  );

  e1cib_slot_timer u_tx_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .advance     (tx_push),
    .frame_start (tx_fs_pulse),
    .bit_pos     (tx_bit_pos),
    .channel     (tx_channel)
  );

  // Gate levels follow the current channel's bit, one pclk behind the counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_gate_reg <= 1'b0;
      tx_gate_reg <= 1'b0;
    end else begin
      rx_gate_reg <= rx_gate_bits_reg[rx_channel];
      tx_gate_reg <= tx_gate_bits_reg[tx_channel];
    end
  end

  assign rx_channel_gate = rx_gate_reg;
  assign tx_channel_gate = tx_gate_reg;

  // Interleaved index: channel c and c+16 share a bit pair
  assign sig_index    = {tx_channel[3:0], tx_channel[4]};
  // Channels 1 and 17 rely on software setting their bits for alignment words
  assign sig_internal = sig_mode & tx_gate_bits_reg[sig_index];

  always @* begin
    tx_bit_next = tx_ser_sync_reg[1];
    if (idle_sel_reg[tx_channel]) begin
      if (subst_on) begin
        tx_bit_next = rx_ser_sync_reg[1];
      end else begin
        tx_bit_next = idle_pattern_reg[~tx_bit_pos];
      end
    end
  end

  e1cib_fifo #(
    .WIDTH  (`E1CIB_FIFO_WIDTH),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_AW)
  ) u_tx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   ({sig_internal, tx_bit_next}),
    .in_valid  (tx_pend_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (tx_line_valid),
    .out_ready (tx_line_ready)
  );

  assign tx_line_data         = fifo_out[0];
  assign tx_line_sig_internal = fifo_out[1];
endmodule

/* tb/e1cib_checker.sv */
// Port assertions for the channel idle and gating block.
// Assumes a single pclk domain and the zero-wait APB answer.
`timescale 1ns/100ps
module e1cib_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        rx_channel_gate,
  input wire        tx_channel_gate,
  input wire        tx_line_data,
  input wire        tx_line_sig_internal,
  input wire        tx_line_valid,
  input wire        tx_line_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A register write may move a gate mid-channel, so recent bus use excuses it
  reg [3:0] quiet_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_reg <= 4'h0;
    else if (psel) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  sequence s_acc;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_stall;
    tx_line_valid && !tx_line_ready;
  endsequence
  property p_rx_hold;
    $changed(rx_channel_gate) && quiet_reg > 4'h4
      |=> (quiet_reg < 4'h5 || $stable(rx_channel_gate))[*8];
  endproperty
  property p_tx_hold;
    $changed(tx_channel_gate) && quiet_reg > 4'h4
      |=> (quiet_reg < 4'h5 || $stable(tx_channel_gate))[*8];
  endproperty
  property p_line_hold;
    s_stall |=> tx_line_valid && $stable(tx_line_data) && $stable(tx_line_sig_internal);
  endproperty
  property p_ready;
    s_acc |-> pready;
  endproperty
  property p_err;
    s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  property p_rdhi;
    s_acc ##0 !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_gate_rst;
    $rose(presetn) |-> !rx_channel_gate && !tx_channel_gate;
  endproperty
  property p_take;
    $fell(tx_line_valid) |-> $past(tx_line_ready);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx gate moved inside a channel");
  a_tx_hold: assert property (p_tx_hold) else $error("tx gate moved inside a channel");
  a_line_hold: assert property (p_line_hold) else $error("line word changed while stalled");
  a_ready: assert property (p_ready) else $error("no ready in access cycle");
  a_err: assert property (p_err) else $error("misaligned access not refused");
  a_rdhi: assert property (p_rdhi) else $error("upper read bits not zero");
  a_gate_rst: assert property (p_gate_rst) else $error("gate high after reset");
  a_take: assert property (p_take) else $error("line word dropped untaken");
endmodule

/* tb/e1cib_sink.sv */
// Line-side consumer of the transmit stream, stalling on command.
// Assumes stall comes from the bench; never ready while in reset.
`timescale 1ns/100ps
module e1cib_sink (
  input  wire       presetn,
  input  wire       stall,
  input  wire       tx_line_data,
  input  wire       tx_line_sig_internal,
  input  wire       tx_line_valid,
  output wire       tx_line_ready,
  output wire       took,
  output wire [1:0] word
);
  assign tx_line_ready = presetn && !stall;
  assign took          = tx_line_valid && tx_line_ready;
  assign word          = {tx_line_sig_internal, tx_line_data};
endmodule

/* tb/e1cib_tb.sv */
// Self-checking bench: APB setup, transmit stream and gate levels vs a model.
// Assumes zero-wait APB and a 9-word transmit store filled before setup.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h00000000;
  reg         rsync = 1'b0;
  reg         stall = 1'b1;
  reg         go = 1'b0;
  reg  [31:0] lf = 32'hE148696E;
  wire [31:0] prdata;
  wire        pready, pslverr, rxg, txg, tdat, tsig, tval, trdy, took;
  wire [1:0]  word;
  reg  [31:0] rd;
  reg         er, gr, gt;
  reg  [7:0]  cfg [0:12];
  reg  [7:0]  ctrl;
  integer     errors = 0, n_tests = 0, n = 0, i, p, k;

  e1cib_top #(.BIT_DIV(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transmit_serial_in(1'b0),
    .receive_serial_out(1'b1), .rx_frame_sync(rsync), .tx_frame_sync(1'b0),
    .rx_channel_gate(rxg), .tx_channel_gate(txg), .tx_line_data(tdat),
    .tx_line_sig_internal(tsig), .tx_line_valid(tval), .tx_line_ready(trdy));
  e1cib_sink sink_u (.presetn(presetn), .stall(stall), .tx_line_data(tdat),
    .tx_line_sig_internal(tsig), .tx_line_valid(tval), .tx_line_ready(trdy),
    .took(took), .word(word));

  always #50 pclk = ~pclk;

  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Words 0..8 were stored under reset settings, before any write landed
  function [1:0] expw(input integer q);
    integer c, b, j;
    begin
      c = (q % 256) / 8;
      b = q % 8;
      j = (c % 16) * 2 + c / 16;
      expw = 2'b00;
      if (q >= 9) begin
        expw[1] = ctrl[6] & cfg[j / 8][j % 8];
        if (cfg[4 + c / 8][c % 8]) expw[0] = ctrl[5] ? 1'b1 : cfg[8][7 - b];
      end
    end
  endfunction

  task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      gr = rxg;
      gt = txg;
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 40) begin
        @(posedge pclk);
        t = t + 1;
      end
      if (t >= 40) errors = errors + 1;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task print_verdict;
    begin
      if (errors == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge pclk) begin
    lf <= nxt(lf);
    stall <= !go || lf[4];
    if (!presetn) n = 0;
    else if (took) begin
      `CHK(word, expw(n))
      n = n + 1;
    end
  end

  initial begin
    for (p = 0; p < 3; p = p + 1) begin
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rsync <= 1'b1;
      @(posedge pclk);
      rsync <= 1'b0;
      repeat (40) @(posedge pclk);
      ctrl = (p == 0) ? 8'h00 : (p == 1) ? 8'h40 : 8'h20;
      for (i = 0; i < 13; i = i + 1) begin
        apb(1'b0, 8'h88 + 8'(i * 4), 32'h0);
        `CHK(rd, 32'h00000000)
        cfg[i] = lf[7:0];
        if (i == 0 && ctrl[6]) cfg[i][1:0] = 2'b11;
        apb(1'b1, 8'h88 + 8'(i * 4), {lf[31:8], cfg[i]});
        apb(1'b0, 8'h88 + 8'(i * 4), 32'h0);
        `CHK(rd, {24'h000000, cfg[i]})
      end
      apb(1'b1, 8'h70, {24'h000000, ctrl});
      apb(1'b0, 8'h70, 32'h0);
      `CHK(rd, {24'h000000, ctrl})
      apb(1'b0, 8'hC0, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h00000000})
      apb(1'b1, 8'h89, 32'hFFFFFFFF);
      `CHK(er, 1'b1)
      apb(1'b0, 8'h88, 32'h0);
      `CHK(rd, {24'h000000, cfg[0]})
      go <= 1'b1;
      k = 0;
      while (n < 300 && k < 400) begin
        apb(1'b0, 8'h74, 32'h0);
        if (rd[10:8] > 0 && rd[10:8] < 7) `CHK(gr, cfg[9 + rd[15:14]][rd[13:11]])
        if (rd[2:0] > 0 && rd[2:0] < 7) `CHK(gt, cfg[rd[7:6]][rd[5:3]])
        repeat (6 + lf[3:0]) @(posedge pclk);
        k = k + 1;
      end
      `CHK(n >= 300, 1'b1)
      go <= 1'b0;
      @(posedge pclk);
    end
    print_verdict;
  end

  initial begin
    #3000000;
    errors = errors + 1;
    print_verdict;
  end
endmodule

bind e1cib_top e1cib_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_channel_gate(rx_channel_gate), .tx_channel_gate(tx_channel_gate),
  .tx_line_data(tx_line_data), .tx_line_sig_internal(tx_line_sig_internal),
  .tx_line_valid(tx_line_valid), .tx_line_ready(tx_line_ready));
